// File: tpg_timer_pwm.v
// tpg_timer_pwm.v: two channel 16-bit modulo timer with pwm output,
// apb register slave, buffered channel pair and flag/irq logic.
// assumes apb signals are synchronous to clk_sys and low power and break
// states arrive as levels from the system controller.
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "tpg_consts.vh"

module tpg_timer_pwm
#(
    parameter WIDTH = 16
)
(
    // clock, reset, enable
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // system states
    input wire wait_mode,
    input wire stop_mode,
    input wire break_active,
    input wire break_clear_enable,
    // input capture events from the edge logic
    input wire [1:0] capture_event,
    // channel pins
    output wire channel0_pin_out,
    output wire channel0_pin_oe,
    output wire channel1_pin_out,
    output wire channel1_pin_oe,
    // requests
    output wire irq_req,
    output wire wake_req
);
    // register state
    reg wrap_flag;
    reg wrap_irq_enable;
    reg counter_halt_bit;
    reg [2:0] prescale_select;
    reg [WIDTH-1:0] period_limit_regs;
    reg [WIDTH-1:0] counter;
    reg [1:0] channel_event_flag;
    reg [1:0] channel_irq_enable;
    reg [5:0] ch_cfg0;
    reg [5:0] ch_cfg1;
    reg [WIDTH-1:0] cmp0;
    reg [WIDTH-1:0] cmp1;
    reg wrap_arm;
    reg [1:0] ch_arm;
    reg active_pair;
    reg pair_pending;
    reg last_written;

    wire acc;
    wire wr;
    wire rd;
    wire clr_ok;
    wire run;
    wire tick;
    wire wrap;
    wire trst;
    wire buffered;
    wire [1:0] out_mode;
    wire [1:0] match;
    wire [1:0] pin_level;
    wire [1:0] flag_set;
    wire [WIDTH-1:0] cmp_sel0;
    wire [2*WIDTH-1:0] cmp_bus;
    wire [5:0] cfg_bus [0:1];
    reg [31:0] next_prdata;

    // true when an access targets the given offset
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    // known offsets answer without error
    function mapped;
        input [7:0] addr;
        begin
            mapped = hit(addr, `TPG_OFS_TSC) || hit(addr, `TPG_OFS_CNT) ||
                     hit(addr, `TPG_OFS_MOD) || hit(addr, `TPG_OFS_SC0) ||
                     hit(addr, `TPG_OFS_CH0) || hit(addr, `TPG_OFS_SC1) ||
                     hit(addr, `TPG_OFS_CH1) || hit(addr, `TPG_OFS_BST);
        end
    endfunction

    // sticky flag update: a set in the clearing cycle wins over the clear
    function next_flag;
        input flag;
        input set;
        input arm;
        input clr_wr;
        begin
            next_flag = set | (flag & ~(arm & clr_wr));
        end
    endfunction

    // first clearing step: a read while set arms, a new set disarms
    function next_arm;
        input arm;
        input flag;
        input set;
        input rd_hit;
        input wr_hit;
        begin
            if (set)
                next_arm = 1'b0;
            else if (rd_hit && flag)
                next_arm = 1'b1;
            else if (wr_hit)
                next_arm = 1'b0;
            else
                next_arm = arm;
        end
    endfunction

    // bus handshake; in wait mode the registers are out of reach
    assign pready = clk_en;
    assign pslverr = psel && penable && (wait_mode || !mapped(paddr));
    assign acc = psel && penable && clk_en && !wait_mode && mapped(paddr);
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    // during break, status bits only change if break clearing is enabled
    assign clr_ok = !break_active || break_clear_enable;

    // counting is frozen by the halt bit, stop mode and break
    assign run = clk_en && !counter_halt_bit && !stop_mode &&
                 !break_active;
    assign trst = wr && hit(paddr, `TPG_OFS_TSC) && pwdata[`TPG_TSC_RST];
    assign wrap = tick && (counter == period_limit_regs);

    tpg_prescaler u_pre
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .clk_en(clk_en),
        .run(run),
        .clear(trst),
        .prescale_select(prescale_select),
        .tick(tick)
    );

    // modulo up-counter: zero and the limit both count, so period = mod + 1
    always @(posedge clk_sys)
    begin
        if (reset)
            counter <= `TPG_RST_CNT;
        else if (clk_en)
        begin
            if (trst)
                counter <= `TPG_RST_CNT;
            else if (wrap)
                counter <= `TPG_RST_CNT;
            else if (tick)
                counter <= counter + 1'b1;
        end
    end

    // buffered mode comes from channel 0 and overrides its bit a
    assign buffered = ch_cfg0[`TPG_SC_MSB - `TPG_SC_CFG_LO];
    assign out_mode[0] = buffered ||
                         (ch_cfg0[`TPG_SC_MSA] &&
                          (ch_cfg0[`TPG_SC_ELSB] ||
                           ch_cfg0[`TPG_SC_ELSA]));
    assign out_mode[1] = !buffered && ch_cfg1[`TPG_SC_MSA] &&
                         (ch_cfg1[`TPG_SC_ELSB] ||
                          ch_cfg1[`TPG_SC_ELSA]);
    assign cmp_sel0 = (buffered && active_pair) ? cmp1 : cmp0;
    assign cmp_bus = {cmp1, cmp_sel0};
    assign cfg_bus[0] = ch_cfg0;
    assign cfg_bus[1] = ch_cfg1;

    // one compare engine per channel
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_ch
            tpg_oc_channel #(.WIDTH(WIDTH)) u_ch
            (
                .clk_sys(clk_sys),
                .reset(reset),
                .clk_en(clk_en),
                .tick(tick),
                .wrap(wrap),
                .count(counter),
                .compare(cmp_bus[gi*WIDTH +: WIDTH]),
                .out_mode(out_mode[gi]),
                .edge_level_sel_lo(cfg_bus[gi][`TPG_SC_ELSA]),
                .toggle_on_wrap_bit(cfg_bus[gi][`TPG_SC_TOV]),
                .full_duty_bit(cfg_bus[gi][`TPG_SC_MAX]),
                .pin_level(pin_level[gi]),
                .match(match[gi])
            );
        end
    endgenerate

    // pins: channel 1 is handed back to port logic in buffered mode
    assign channel0_pin_out = pin_level[0];
    assign channel0_pin_oe = out_mode[0];
    assign channel1_pin_out = pin_level[1];
    assign channel1_pin_oe = out_mode[1];

    // captures are blocked while frozen; channel 1 is dead when buffered
    assign flag_set[0] = match[0] || (capture_event[0] && run);
    assign flag_set[1] = !buffered &&
                         (match[1] || (capture_event[1] && run));

    // active pair: switch at wrap to the pair written last
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            active_pair <= 1'b0;
            pair_pending <= 1'b0;
            last_written <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!buffered)
            begin
                active_pair <= 1'b0;
                pair_pending <= 1'b0;
            end
            else
            begin
                if (wrap && pair_pending)
                    active_pair <= last_written;
                if (wr && (hit(paddr, `TPG_OFS_CH0) ||
                           hit(paddr, `TPG_OFS_CH1)))
                begin
                    last_written <= hit(paddr, `TPG_OFS_CH1);
                    pair_pending <= 1'b1;
                end
                else if (wrap)
                    pair_pending <= 1'b0;
            end
        end
    end

    // control registers; the counter reset bit is a strobe, never stored
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wrap_irq_enable <= 1'b0;
            counter_halt_bit <= 1'b1;
            prescale_select <= `TPG_RST_PS;
            period_limit_regs <= `TPG_RST_MOD;
            channel_irq_enable <= 2'h0;
            ch_cfg0 <= `TPG_RST_CFG;
            ch_cfg1 <= `TPG_RST_CFG;
            cmp0 <= {WIDTH{1'b0}};
            cmp1 <= {WIDTH{1'b0}};
        end
        else if (wr)
        begin
            if (hit(paddr, `TPG_OFS_TSC))
            begin
                wrap_irq_enable <= pwdata[`TPG_TSC_IE];
                counter_halt_bit <= pwdata[`TPG_TSC_HALT];
                prescale_select <= pwdata[`TPG_TSC_PS_HI:`TPG_TSC_PS_LO];
            end
            if (hit(paddr, `TPG_OFS_MOD))
                period_limit_regs <= pwdata[WIDTH-1:0];
            if (hit(paddr, `TPG_OFS_SC0))
            begin
                channel_irq_enable[0] <= pwdata[`TPG_SC_IE];
                ch_cfg0 <= pwdata[`TPG_SC_CFG_HI:`TPG_SC_CFG_LO];
            end
            if (hit(paddr, `TPG_OFS_SC1) && !buffered)
            begin
                channel_irq_enable[1] <= pwdata[`TPG_SC_IE];
                ch_cfg1 <= pwdata[`TPG_SC_CFG_HI:`TPG_SC_CFG_LO];
            end
            if (hit(paddr, `TPG_OFS_CH0))
                cmp0 <= pwdata[WIDTH-1:0];
            if (hit(paddr, `TPG_OFS_CH1))
                cmp1 <= pwdata[WIDTH-1:0];
        end
    end

    // flags: read while set, then write zero; writing one does nothing
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            wrap_flag <= 1'b0;
            wrap_arm <= 1'b0;
            channel_event_flag <= 2'h0;
            ch_arm <= 2'h0;
        end
        else if (clk_en)
        begin
            wrap_flag <= next_flag(wrap_flag, wrap, wrap_arm,
                wr && clr_ok && hit(paddr, `TPG_OFS_TSC) &&
                !pwdata[`TPG_TSC_FLAG]);
            wrap_arm <= next_arm(wrap_arm, wrap_flag, wrap,
                rd && clr_ok && hit(paddr, `TPG_OFS_TSC),
                wr && clr_ok && hit(paddr, `TPG_OFS_TSC));
            channel_event_flag[0] <= next_flag(channel_event_flag[0],
                flag_set[0], ch_arm[0],
                wr && clr_ok && hit(paddr, `TPG_OFS_SC0) &&
                !pwdata[`TPG_SC_FLAG]);
            ch_arm[0] <= next_arm(ch_arm[0], channel_event_flag[0],
                flag_set[0], rd && clr_ok && hit(paddr, `TPG_OFS_SC0),
                wr && clr_ok && hit(paddr, `TPG_OFS_SC0));
            channel_event_flag[1] <= next_flag(channel_event_flag[1],
                flag_set[1], ch_arm[1],
                wr && clr_ok && !buffered && hit(paddr, `TPG_OFS_SC1) &&
                !pwdata[`TPG_SC_FLAG]);
            ch_arm[1] <= next_arm(ch_arm[1], channel_event_flag[1],
                flag_set[1], rd && clr_ok && hit(paddr, `TPG_OFS_SC1),
                wr && clr_ok && hit(paddr, `TPG_OFS_SC1));
        end
    end

    // requests gated by enables; the same level wakes the controller
    assign irq_req = (wrap_flag && wrap_irq_enable) ||
                     (channel_event_flag[0] && channel_irq_enable[0]) ||
                     (channel_event_flag[1] && channel_irq_enable[1] &&
                      !buffered);
    assign wake_req = irq_req;

    // read mux, sampled in the setup phase so data is a flop in access
    always @*
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            `TPG_OFS_TSC:
            begin
                next_prdata[`TPG_TSC_FLAG] = wrap_flag;
                next_prdata[`TPG_TSC_IE] = wrap_irq_enable;
                next_prdata[`TPG_TSC_HALT] = counter_halt_bit;
                next_prdata[`TPG_TSC_PS_HI:`TPG_TSC_PS_LO] = prescale_select;
            end
            `TPG_OFS_CNT: next_prdata[WIDTH-1:0] = counter;
            `TPG_OFS_MOD: next_prdata[WIDTH-1:0] = period_limit_regs;
            `TPG_OFS_SC0:
            begin
                next_prdata[`TPG_SC_FLAG] = channel_event_flag[0];
                next_prdata[`TPG_SC_IE] = channel_irq_enable[0];
                next_prdata[`TPG_SC_CFG_HI:`TPG_SC_CFG_LO] = ch_cfg0;
            end
            `TPG_OFS_CH0: next_prdata[WIDTH-1:0] = cmp0;
            `TPG_OFS_SC1:
            begin
                next_prdata[`TPG_SC_FLAG] = channel_event_flag[1];
                next_prdata[`TPG_SC_IE] = channel_irq_enable[1];
                next_prdata[`TPG_SC_CFG_HI:`TPG_SC_CFG_LO] = ch_cfg1;
            end
            `TPG_OFS_CH1: next_prdata[WIDTH-1:0] = cmp1;
            `TPG_OFS_BST: next_prdata[0] = active_pair;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    // read data register
    always @(posedge clk_sys)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (clk_en && psel && !penable)
            prdata <= next_prdata;
    end
endmodule // tpg_timer_pwm

// File: tpg_consts.vh
// tpg_consts.vh: register map, field positions and reset values of the
// timer pwm channel block; definitions only, included by bare name.
`ifndef TPG_CONSTS_VH
`define TPG_CONSTS_VH

// register byte offsets on the apb bus
`define TPG_OFS_TSC 8'h00
`define TPG_OFS_CNT 8'h04
`define TPG_OFS_MOD 8'h08
`define TPG_OFS_SC0 8'h0c
`define TPG_OFS_CH0 8'h10
`define TPG_OFS_SC1 8'h14
`define TPG_OFS_CH1 8'h18
`define TPG_OFS_BST 8'h1c

// timer status/control fields
`define TPG_TSC_FLAG 7
`define TPG_TSC_IE 6
`define TPG_TSC_HALT 5
`define TPG_TSC_RST 4
`define TPG_TSC_PS_HI 2
`define TPG_TSC_PS_LO 0

// channel status/control fields
`define TPG_SC_FLAG 7
`define TPG_SC_IE 6
`define TPG_SC_MSB 5
`define TPG_SC_MSA 4
`define TPG_SC_ELSB 3
`define TPG_SC_ELSA 2
`define TPG_SC_TOV 1
`define TPG_SC_MAX 0
`define TPG_SC_CFG_HI 5
`define TPG_SC_CFG_LO 0

// reset values
`define TPG_RST_MOD 16'hffff
`define TPG_RST_CNT 16'h0000
`define TPG_RST_PS 3'h0
`define TPG_RST_CFG 6'h00

// prescale stage count and the unused select code
`define TPG_PRE_BITS 6
`define TPG_PS_UNUSED 3'h7

`endif

// File: tpg_prescaler.v
// tpg_prescaler.v: bus clock divider giving the counter clock tick.
// assumes run is low whenever the counter must hold still.
`timescale 1ns/10ps
`include "tpg_consts.vh"

module tpg_prescaler
(
    // clock and reset
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // control
    input wire run,
    input wire clear,
    input wire [2:0] prescale_select,
    // timer clock event
    output wire tick
);
    reg [`TPG_PRE_BITS-1:0] stage;
    wire [`TPG_PRE_BITS-1:0] mask;

    // divide by 2^select: tick when all selected low stage bits are ones
    assign mask = ~({`TPG_PRE_BITS{1'b1}} << prescale_select);
    assign tick = run && (prescale_select != `TPG_PS_UNUSED) &&
                  ((stage & mask) == mask);

    // stage counter; clear wins so a counter reset restarts the divider
    always @(posedge clk_sys)
    begin
        if (reset)
            stage <= {`TPG_PRE_BITS{1'b0}};
        else if (clk_en)
        begin
            if (clear)
                stage <= {`TPG_PRE_BITS{1'b0}};
            else if (run)
                stage <= stage + 1'b1;
        end
    end
endmodule // tpg_prescaler

// File: tpg_oc_channel.v
// tpg_oc_channel.v: one output compare channel with toggle on wrap.
// assumes count, wrap and tick come from the shared modulo counter.
`timescale 1ns/10ps
`include "tpg_consts.vh"

module tpg_oc_channel
#(
    parameter WIDTH = 16
)
(
    // clock and reset
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // counter
    input wire tick,
    input wire wrap,
    input wire [WIDTH-1:0] count,
    input wire [WIDTH-1:0] compare,
    // configuration
    input wire out_mode,
    input wire edge_level_sel_lo,
    input wire toggle_on_wrap_bit,
    input wire full_duty_bit,
    // results
    output reg pin_level,
    output wire match
);
    // live compare against the written value, no shadow copy
    assign match = out_mode && tick && (count == compare);

    // wrap toggles, compare forces the level picked by the low select bit
    always @(posedge clk_sys)
    begin
        if (reset)
            pin_level <= 1'b0;
        else if (clk_en && out_mode)
        begin
            if (full_duty_bit && toggle_on_wrap_bit)
                pin_level <= ~edge_level_sel_lo;
            else if (wrap && toggle_on_wrap_bit)
                pin_level <= ~pin_level;
            else if (match)
                pin_level <= edge_level_sel_lo;
        end
    end
endmodule // tpg_oc_channel

// File: tpg_timer_pwm_assertions.sv
// tpg_timer_pwm_assertions.sv: port-level checker for the pwm timer block.
// assumes one clock domain and apb writes that land at the access edge.
`timescale 1ns/10ps

module tpg_timer_pwm_assertions
(
    // clock and reset
    input wire clk_sys,
    input wire reset,
    input wire clk_en,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // states and outputs
    input wire wait_mode,
    input wire stop_mode,
    input wire break_active,
    input wire channel0_pin_out,
    input wire channel1_pin_oe,
    input wire irq_req,
    input wire wake_req
);
    reg buf_on;
    reg ie_w;
    reg ie0;
    reg ie1;
    wire wr_ok = psel && penable && pwrite && clk_en && !pslverr;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // shadow of the enable bits, so the irq can be tied to its causes
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            buf_on <= 1'b0;
            ie_w <= 1'b0;
            ie0 <= 1'b0;
            ie1 <= 1'b0;
        end
        else if (wr_ok)
        begin
            if (paddr == 8'h00)
                ie_w <= pwdata[6];
            if (paddr == 8'h0c)
                ie0 <= pwdata[6];
            if (paddr == 8'h0c)
                buf_on <= pwdata[5];
            if (paddr == 8'h14 && !buf_on)
                ie1 <= pwdata[6];
        end
    end

    a_ready_tracks_en: assert property (pready == clk_en)
        else $error("pready differs from clk_en");
    a_wake_follows_irq: assert property (wake_req == irq_req)
        else $error("wake request differs from irq request");
    a_wait_refuses_access: assert property (
        psel && penable && wait_mode |-> pslverr)
        else $error("access in wait mode not refused");
    a_unmapped_reads_zero: assert property (psel && penable && !pwrite &&
        paddr > 8'h1c |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_rst_bit_zero: assert property (psel && penable && !pwrite &&
        paddr == 8'h00 && !wait_mode |-> !prdata[4])
        else $error("counter reset bit read back as one");
    a_prdata_holds: assert property (!$past(psel && !penable)
        |-> $stable(prdata))
        else $error("read data moved outside a setup edge");
    a_ch1_pin_released: assert property (buf_on |-> !channel1_pin_oe)
        else $error("channel one pin driven in buffered mode");
    a_stop_holds_pin: assert property (stop_mode && $past(stop_mode) &&
        $past(stop_mode, 2) |-> $stable(channel0_pin_out))
        else $error("pin moved in stop mode");
    a_break_holds_pin: assert property (break_active &&
        $past(break_active) && $past(break_active, 2)
        |-> $stable(channel0_pin_out))
        else $error("pin moved during break");
    a_irq_needs_enable: assert property (
        irq_req |-> ie_w || ie0 || ie1)
        else $error("irq without any enable");

    c_irq_rise: cover property ($rose(irq_req));
    c_buffered_pulse: cover property (buf_on && $rose(channel0_pin_out));
    c_refused: cover property (pslverr && psel && penable);
endmodule // tpg_timer_pwm_assertions

bind tpg_timer_pwm tpg_timer_pwm_assertions tpg_timer_pwm_assertions_i
(
    .clk_sys, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .wait_mode, .stop_mode, .break_active,
    .channel0_pin_out, .channel1_pin_oe, .irq_req, .wake_req
);

// File: tpg_timer_pwm_tb_top.sv
// tpg_timer_pwm_tb_top.sv: self-checking bench for the pwm timer block.
// assumes the block answers apb with pready and uses the listed offsets.
`timescale 1ns/10ps
`include "tpg_consts.vh"

module tpg_timer_pwm_tb_top;
    typedef struct {logic [2:0] ps; logic [15:0] md; logic [15:0] cm;
        logic [15:0] pe; logic [15:0] he;} tpg_row_t;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic wait_mode = 1'b0;
    logic stop_mode = 1'b0;
    logic break_active = 1'b0;
    logic [1:0] capture_event = 2'h0;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire channel0_pin_out;
    wire channel1_pin_oe;
    wire irq_req;
    wire wake_req;
    int n_mismatch = 0;
    int compares = 0;
    int hi;
    int per;
    int n;
    logic [31:0] q;
    logic [31:0] c0;
    logic err;
    // every usable prescale code (0 to 6) once; compare below modulo; period, pulse expected
    tpg_row_t rows [7] = '{'{3'h0, 16'hff, 16'h7f, 16'h100, 16'h80},
        '{3'h1, 16'h9, 16'h3, 16'h14, 16'h8},
        '{3'h2, 16'h5, 16'h0, 16'h18, 16'h4},
        '{3'h3, 16'h3, 16'h2, 16'h20, 16'h18},
        '{3'h4, 16'h2, 16'h1, 16'h30, 16'h20},
        '{3'h5, 16'h1, 16'h0, 16'h40, 16'h20},
        '{3'h6, 16'h2, 16'h0, 16'hc0, 16'h40}};

    tpg_timer_pwm tpg_timer_pwm_i (.clk_sys, .reset, .clk_en(1'b1), .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wait_mode, .stop_mode, .break_active, .break_clear_enable(1'b0),
        .capture_event, .channel0_pin_out, .channel0_pin_oe(),
        .channel1_pin_out(), .channel1_pin_oe, .irq_req, .wake_req);

    always #4 clk_sys = ~clk_sys;

    task chk(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; waits on pready, the watchdog ends a hang
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cfg(input logic [2:0] ps, input logic [15:0] md,
        input logic [15:0] cm, input logic [7:0] sc);
        apb(1'b1, `TPG_OFS_TSC, 32'h30);
        apb(1'b1, `TPG_OFS_MOD, {16'h0, md});
        apb(1'b1, `TPG_OFS_CH0, {16'h0, cm});
        apb(1'b1, `TPG_OFS_SC0, {24'h0, sc});
        apb(1'b1, `TPG_OFS_TSC, {29'h0, ps});
    endtask

    // high time and rise-to-rise period of the channel zero pin
    task meas;
        n = 0;
        @(negedge clk_sys);
        while (channel0_pin_out !== 1'b0 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        while (channel0_pin_out !== 1'b1 && n < 3000)
        begin
            @(negedge clk_sys);
            n++;
        end
        hi = 0;
        while (channel0_pin_out === 1'b1 && hi < 3000)
        begin
            @(negedge clk_sys);
            hi++;
        end
        per = hi;
        while (channel0_pin_out === 1'b0 && per < 3000)
        begin
            @(negedge clk_sys);
            per++;
        end
    endtask

    task flips;
        logic last;
        n = 0;
        repeat (40) @(negedge clk_sys);
        last = channel0_pin_out;
        repeat (100)
        begin
            @(negedge clk_sys);
            n += (channel0_pin_out !== last);
            last = channel0_pin_out;
        end
    endtask

    task wait_irq;
        n = 0;
        while (irq_req !== 1'b1 && n < 1000)
        begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    task results;
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #400000;
        n_mismatch++;
        results;
    end

    initial
    begin
        repeat (8) @(posedge clk_sys);
        reset <= 1'b0;
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q, 32'h20, "ctl reset");
        apb(1'b0, `TPG_OFS_MOD, 32'h0);
        chk(q, 32'hffff, "modulo reset");
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk(q, 32'h0, "counter reset");
        foreach (rows[i])
        begin
            cfg(rows[i].ps, rows[i].md, rows[i].cm, 8'h1a);
            meas;
            chk(32'(per), {16'h0, rows[i].pe}, "period");
            chk(32'(hi), {16'h0, rows[i].he}, "pulse");
        end
        cfg(3'h0, 16'h9, 16'h4, 8'h18);
        flips;
        chk(32'(n), 32'h0, "zero duty flips");
        cfg(3'h0, 16'h9, 16'h4, 8'h1b);
        flips;
        chk(32'(n), 32'h0, "full duty flips");
        chk({31'h0, channel0_pin_out}, 32'h1, "full duty level");
        cfg(3'h0, 16'h9, 16'h4, 8'h5a);
        wait_irq;
        chk({31'h0, irq_req}, 32'h1, "channel irq");
        apb(1'b1, `TPG_OFS_CH0, 32'h1);
        apb(1'b0, `TPG_OFS_SC0, 32'h0);
        chk(q & 32'h80, 32'h80, "channel flag");
        meas;
        chk(32'(hi), 32'h2, "shorter pulse");
        // buffered pair, bit a set too and overridden
        cfg(3'h0, 16'h9, 16'h2, 8'h3a);
        meas;
        chk(32'(hi), 32'h3, "pair zero pulse");
        chk({31'h0, channel1_pin_oe}, 32'h0, "ch1 pin oe");
        apb(1'b1, `TPG_OFS_SC1, 32'h5a);
        apb(1'b0, `TPG_OFS_SC1, 32'h0);
        chk(q, 32'h0, "ch1 ctl ignored");
        apb(1'b1, `TPG_OFS_CH1, 32'h5);
        meas;
        chk(32'(hi), 32'h6, "pair one pulse");
        apb(1'b0, `TPG_OFS_BST, 32'h0);
        chk(q, 32'h1, "active pair");
        // wrap flag: set, failed clear, clear, write of one
        cfg(3'h0, 16'h9, 16'h2, 8'h1a);
        apb(1'b1, `TPG_OFS_TSC, 32'h40);
        wait_irq;
        chk({31'h0, irq_req}, 32'h1, "wrap irq");
        apb(1'b1, `TPG_OFS_TSC, 32'h60);
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q, 32'he0, "clear without read");
        apb(1'b1, `TPG_OFS_TSC, 32'h60);
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q, 32'h60, "read then clear");
        chk({31'h0, irq_req}, 32'h0, "irq after clear");
        apb(1'b1, `TPG_OFS_TSC, 32'he0);
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q, 32'h60, "write one to flag");
        // break: counter frozen, arm from before break survives
        apb(1'b1, `TPG_OFS_MOD, 32'hc8);
        apb(1'b1, `TPG_OFS_TSC, 32'h40);
        wait_irq;
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        break_active <= 1'b1;
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        c0 = q;
        repeat (20) @(posedge clk_sys);
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk(q, c0, "counter in break");
        capture_event <= 2'h2;
        @(posedge clk_sys);
        capture_event <= 2'h0;
        apb(1'b0, `TPG_OFS_SC1, 32'h0);
        chk(q & 32'h80, 32'h0, "capture in break");
        apb(1'b1, `TPG_OFS_TSC, 32'h40);
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q & 32'h80, 32'h80, "flag kept in break");
        break_active <= 1'b0;
        apb(1'b1, `TPG_OFS_TSC, 32'h40);
        apb(1'b0, `TPG_OFS_TSC, 32'h0);
        chk(q & 32'h80, 32'h0, "clear after break");
        capture_event <= 2'h2;
        @(posedge clk_sys);
        capture_event <= 2'h0;
        apb(1'b0, `TPG_OFS_SC1, 32'h0);
        chk(q & 32'h80, 32'h80, "capture flag");
        // stop freezes, then resumes; stop set before the count is read
        stop_mode <= 1'b1;
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        c0 = q;
        repeat (20) @(posedge clk_sys);
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk(q, c0, "counter in stop");
        stop_mode <= 1'b0;
        repeat (20) @(posedge clk_sys);
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk({31'h0, q === c0}, 32'h0, "counter resumes");
        wait_mode <= 1'b1;
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk({31'h0, err}, 32'h1, "access in wait");
        wait_mode <= 1'b0;
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(q, 32'h0, "unmapped data");
        // unused prescale code never ticks; reset bit zeroes the count
        apb(1'b1, `TPG_OFS_TSC, 32'h37);
        apb(1'b1, `TPG_OFS_TSC, 32'h07);
        repeat (50) @(posedge clk_sys);
        apb(1'b0, `TPG_OFS_CNT, 32'h0);
        chk(q, 32'h0, "unused prescale");
        results;
    end
endmodule // tpg_timer_pwm_tb_top
